// file: rtl/dmsd_pkg.sv
// Constants for the demodulator monitor sigma-delta converter
package dmsd_pkg;
	// Register indices
	localparam logic [3:0] DMSD_IDX_TEST = 4'hC;
	localparam logic [3:0] DMSD_IDX_OFFGAIN = 4'hD;
	localparam logic [3:0] DMSD_IDX_CTRL = 4'hE;
	localparam logic [3:0] DMSD_IDX_STATUS = 4'hF;
	// Test register fields
	localparam int DMSD_TMODE_LSB = 14;
	localparam int DMSD_TMODE_W = 5;
	localparam logic [4:0] DMSD_TMODE_PLAIN = 5'h07;
	localparam logic [4:0] DMSD_TMODE_OFFSET = 5'h0A;
	localparam logic [31:0] DMSD_TEST_RST = 32'h0000_0000;
	// Offset and gain register fields
	localparam int DMSD_OFF_LSB = 16;
	localparam int DMSD_OFF_W = 10;
	localparam int DMSD_GAIN_LSB = 26;
	localparam int DMSD_GAIN_W = 3;
	localparam logic [31:0] DMSD_OFFGAIN_RST = 32'h0000_0000;
	// Offset field is padded by 12 zero bits and shifted back, so it is not scaled
	localparam int DMSD_OFF_SHIFT = 12;
	// Control register: bit 0 selects the linear demodulator
	localparam int DMSD_CTRL_LIN = 0;
	localparam int DMSD_CTRL_W = 8;
	localparam logic [7:0] DMSD_CTRL_RST = 8'h00;
	localparam logic [7:0] DMSD_RECOV_DIV_RST = 8'h02;
	// Last count of the tick rate window
	localparam logic [7:0] DMSD_RATE_WIN = 8'hFF;
	// Nominal intermediate frequency and removable offset
	localparam int DMSD_IF_HZ = 200000;
	localparam int DMSD_MAX_OFF_HZ = 300000;
	// Converter states
	typedef enum logic [1:0] {
		DMSD_IDLE = 2'b00,
		DMSD_PLAIN = 2'b01,
		DMSD_OFFS = 2'b10
	} dmsd_mode_t;
endpackage

// file: rtl/dmsd_buf2.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
module dmsd_buf2 #(
	parameter int WIDTH = 16
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	logic [WIDTH-1:0] mem_r [2];
	logic rd_r;
	logic wr_r;
	logic [1:0] cnt_r;
	logic push;
	logic pop;

	initial begin
		if (WIDTH < 1) $error("width too small");
	end

	assign in_ready = (cnt_r != 2'd2);
	assign out_valid = (cnt_r != 2'd0);
	assign out_data = mem_r[rd_r];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge mclk) begin
		if (push) begin
			mem_r[wr_r] <= in_data;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rd_r <= 1'b0;
			wr_r <= 1'b0;
			cnt_r <= 2'd0;
		end else begin
			if (push) wr_r <= ~wr_r;
			if (pop) rd_r <= ~rd_r;
			cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule

// file: rtl/dmsd_mod2.sv
// Second-order error-feedback sigma-delta modulator
`timescale 1ns/10ps
module dmsd_mod2 #(
	parameter int WIDTH = 16
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// Sample step and input word
	input wire logic step,
	input wire logic run,
	input wire logic signed [WIDTH-1:0] din,
	// Single-bit output
	output logic bit_out
);
	localparam int AW = WIDTH + 3;
	logic signed [AW-1:0] e1_r;
	logic signed [AW-1:0] e2_r;
	logic signed [AW-1:0] v;
	logic signed [AW-1:0] fb;
	logic signed [AW-1:0] err;

	initial begin
		if (WIDTH < 2) $error("width too small");
	end

	// v = x + 2e1 - e2, error feedback of (1 - z^-1)^2
	always_comb begin
		v = AW'(din) + (e1_r <<< 1) - e2_r;
		fb = v[AW-1] ? -AW'(signed'({1'b0, {(WIDTH-1){1'b1}}}))
			: AW'(signed'({1'b0, {(WIDTH-1){1'b1}}}));
		err = fb - v;
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			e1_r <= '0;
			e2_r <= '0;
			bit_out <= 1'b0;
		end else if (!run) begin
			e1_r <= '0;
			e2_r <= '0;
			bit_out <= 1'b0;
		end else if (step) begin
			e2_r <= e1_r;
			e1_r <= -err;
			bit_out <= ~v[AW-1];
		end
	end
endmodule

// file: rtl/dmsd_top.sv
// Demodulator monitor sigma-delta converter, top level
`timescale 1ns/10ps
// How it works
// [R01] The 16-bit filter word becomes a one-bit stream by a second-order error-feedback modulator.
// [R02] While the converter is on, the stream appears on the bitstream output pin.
// [R03] The modulator steps on the recovery clock tick, the filter words arrive on the demodulator tick.
// [R04] Recovery ticks at or above the demodulator rate stop clock recovery, flagged in status.
// [R05] Test mode 7 enables the converter with no offset removal.
// [R06] Test mode 10 enables the converter with offset removal, meant for the linear demodulator.
// [R07] The converter input comes from whichever demodulator is active.
// [R08] Software programs half the measured intermediate frequency as the offset.
// [R09] In offset mode the converter input is two to the gain times signal minus offset.
// [R10] With neither mode selected the path is idle and the pin keeps its normal clock.
// [R11] The nominal intermediate frequency is 200 kHz.
// [R12] Software sets the recovery divider near 32 times the data rate.
module dmsd_top
	import dmsd_pkg::*;
#(
	parameter int WIDTH = 16
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Demodulator filter outputs
	input wire logic demod_tick,
	input wire logic signed [WIDTH-1:0] corr_filt,
	input wire logic signed [WIDTH-1:0] lin_filt,
	// Recovery clock tick and normal clock output
	input wire logic recovery_tick,
	input wire logic normal_bitstream_output_pin,
	// Pin
	output logic bitstream_output_pin,
	output logic cdr_disabled
);
	logic [31:0] test_r;
	logic [31:0] offgain_r;
	logic [DMSD_CTRL_W-1:0] ctrl_r;
	dmsd_mode_t mode_r;
	dmsd_mode_t mode_nxt;
	logic [DMSD_TMODE_W-1:0] tmode;
	logic lin_sel;
	logic signed [WIDTH-1:0] src;
	logic signed [WIDTH+1:0] diff;
	logic signed [WIDTH+9:0] scaled;
	logic signed [WIDTH-1:0] conv_in;
	logic signed [WIDTH-1:0] sample_r;
	logic buf_in_ready;
	logic buf_out_valid;
	logic [WIDTH-1:0] buf_out_data;
	logic sd_bit;
	logic run;
	logic [7:0] rec_cnt_r;
	logic [7:0] dem_cnt_r;
	logic fast_r;
	logic drop_r;
	logic pin_r;
	logic [2:0] gain;
	logic signed [WIDTH+1:0] off_term;

	initial begin
		if (WIDTH != 16) $error("converter input is 16 bits");
		if (DMSD_IF_HZ > DMSD_MAX_OFF_HZ) begin
			$error("nominal offset not removable"); // [R11]
		end
	end

	assign tmode = test_r[DMSD_TMODE_LSB +: DMSD_TMODE_W];
	assign lin_sel = ctrl_r[DMSD_CTRL_LIN];
	assign gain = offgain_r[DMSD_GAIN_LSB +: DMSD_GAIN_W];

	// Register writes
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			test_r <= DMSD_TEST_RST;
			offgain_r <= DMSD_OFFGAIN_RST;
			ctrl_r <= DMSD_CTRL_RST;
		end else if (reg_wr) begin
			unique case (reg_addr)
				DMSD_IDX_TEST: test_r <= reg_wdata; // [R05] [R06]
				DMSD_IDX_OFFGAIN: offgain_r <= reg_wdata; // [R08]
				DMSD_IDX_CTRL: ctrl_r <= reg_wdata[DMSD_CTRL_W-1:0];
				default: ;
			endcase
		end
	end

	// Register reads, data one cycle later
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			unique case (reg_addr)
				DMSD_IDX_TEST: reg_rdata <= test_r;
				DMSD_IDX_CTRL: reg_rdata <= {24'h000000, ctrl_r};
				DMSD_IDX_STATUS: reg_rdata <= {28'h0000000, drop_r,
					fast_r, mode_r};
				default: reg_rdata <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

	// Converter mode decode
	always_comb begin
		if (tmode == DMSD_TMODE_PLAIN) begin
			mode_nxt = DMSD_PLAIN; // [R05]
		end else if (tmode == DMSD_TMODE_OFFSET) begin
			mode_nxt = DMSD_OFFS; // [R06]
		end else begin
			mode_nxt = DMSD_IDLE; // [R10]
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			mode_r <= DMSD_IDLE;
		end else begin
			mode_r <= mode_nxt;
		end
	end

	assign run = (mode_r != DMSD_IDLE);

	// Active demodulator selects the source
	assign src = lin_sel ? lin_filt : corr_filt; // [R07]

	// Offset removal and power-of-two gain
	assign off_term = (WIDTH+2)'(signed'({1'b0,
		offgain_r[DMSD_OFF_LSB +: DMSD_OFF_W], 12'h000}) >>> DMSD_OFF_SHIFT);
	always_comb begin
		if (mode_r == DMSD_OFFS) begin
			diff = (WIDTH+2)'(src) - off_term; // [R09]
		end else begin
			diff = (WIDTH+2)'(src);
		end
		scaled = (WIDTH+10)'(diff) <<< gain; // [R09]
		if (mode_r != DMSD_OFFS) begin
			conv_in = src;
		end else if (scaled > (WIDTH+10)'(32767)) begin
			conv_in = 16'h7FFF;
		end else if (scaled < -(WIDTH+10)'(32768)) begin
			conv_in = 16'h8000;
		end else begin
			conv_in = scaled[WIDTH-1:0];
		end
	end

	// Words cross from the demodulator tick to the recovery tick
	dmsd_buf2 #(
		.WIDTH(WIDTH)
	) dmsd_buf2_inst (
		.mclk(mclk),
		.rstn(rstn),
		.in_valid(demod_tick && run), // [R03]
		.in_ready(buf_in_ready),
		.in_data(conv_in),
		.out_valid(buf_out_valid),
		.out_ready(recovery_tick),
		.out_data(buf_out_data)
	);

	// Sample held for the modulator
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			sample_r <= '0;
			drop_r <= 1'b0;
		end else begin
			if (!run) begin
				sample_r <= '0;
			end else if (buf_out_valid && recovery_tick) begin
				sample_r <= signed'(buf_out_data);
			end
			if (demod_tick && run && !buf_in_ready) begin
				drop_r <= 1'b1;
			end else if (reg_rd && reg_addr == DMSD_IDX_STATUS) begin
				drop_r <= 1'b0;
			end
		end
	end

	dmsd_mod2 #(
		.WIDTH(WIDTH)
	) dmsd_mod2_inst (
		.mclk(mclk),
		.rstn(rstn),
		.step(recovery_tick), // [R03]
		.run(run),
		.din(sample_r),
		.bit_out(sd_bit) // [R01]
	);

	// Compare tick rates over a window for the recovery flag
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rec_cnt_r <= '0;
			dem_cnt_r <= '0;
			fast_r <= 1'b0;
		end else if (dem_cnt_r == DMSD_RATE_WIN) begin
			fast_r <= (rec_cnt_r >= dem_cnt_r); // [R04]
			rec_cnt_r <= '0;
			dem_cnt_r <= '0;
		end else begin
			dem_cnt_r <= dem_cnt_r + {7'h00, demod_tick};
			if (rec_cnt_r != DMSD_RATE_WIN) begin
				rec_cnt_r <= rec_cnt_r + {7'h00, recovery_tick};
			end
		end
	end

	assign cdr_disabled = fast_r; // [R04]

	// Pin mux
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pin_r <= 1'b0;
		end else begin
			pin_r <= run ? sd_bit : normal_bitstream_output_pin; // [R02] [R10]
		end
	end

	assign bitstream_output_pin = pin_r;
endmodule

// file: test/dmsd_top_props.sv
// Port checker for the sigma-delta monitor
`timescale 1ns/10ps
module dmsd_props
	import dmsd_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	// Ticks and pins
	input wire logic recovery_tick,
	input wire logic normal_bitstream_output_pin,
	input wire logic bitstream_output_pin,
	input wire logic cdr_disabled
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	logic [1:0] md_r;
	logic [7:0] ctl_r;
	logic [4:0] fld;
	logic on;
	assign fld = reg_wdata[DMSD_TMODE_LSB +: DMSD_TMODE_W];
	assign on = md_r != 2'h0;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			md_r <= 2'h0;
		else if (reg_wr && reg_addr == DMSD_IDX_TEST)
			md_r <= {fld == DMSD_TMODE_OFFSET, fld == DMSD_TMODE_PLAIN};
	end
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			ctl_r <= DMSD_CTRL_RST;
		else if (reg_wr && reg_addr == DMSD_IDX_CTRL)
			ctl_r <= reg_wdata[7:0];
	end
	sequence s_rd(a);
		reg_rd && reg_addr == a;
	endsequence
	sequence s_quiet;
		on ##1 on && !recovery_tick ##1 on;
	endsequence
	a_reset_clear: assert property ($rose(rstn) |->
		!bitstream_output_pin && !cdr_disabled && reg_rdata == 32'h0)
		else $error("outputs not clear after reset");
	a_rdata_quiet: assert property (!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data without read");
	a_offgain_hidden: assert property (s_rd(DMSD_IDX_OFFGAIN) |=>
		reg_rdata == 32'h0) else $error("offset register readable");
	a_unmapped_zero: assert property (reg_rd && reg_addr < DMSD_IDX_TEST
		|=> reg_rdata == 32'h0) else $error("unmapped read not zero");
	a_status_mode: assert property (s_rd(DMSD_IDX_STATUS) |=>
		reg_rdata[1:0] == $past(md_r, 2))
		else $error("wrong mode in status");
	a_ctrl_echo: assert property (s_rd(DMSD_IDX_CTRL) |=>
		reg_rdata == {24'h0, $past(ctl_r)}) else $error("ctrl readback");
	a_idle_pin_clock: assert property (!on [*3] |->
		bitstream_output_pin == $past(normal_bitstream_output_pin))
		else $error("idle pin not normal clock");
	a_step_on_tick: assert property (s_quiet |=>
		$stable(bitstream_output_pin)) else $error("bit moved without step");
endmodule
bind dmsd_top dmsd_props dmsd_props_inst (.mclk(mclk), .rstn(rstn),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .recovery_tick(recovery_tick),
	.normal_bitstream_output_pin(normal_bitstream_output_pin), .cdr_disabled(cdr_disabled),
	.bitstream_output_pin(bitstream_output_pin));

// file: test/dmsd_meter.sv
// Bit density meter in place of the external filter
`timescale 1ns/10ps
module dmsd_meter (
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// Stream, step and restart
	input wire logic bit_in,
	input wire logic step,
	input wire logic clr,
	// Ones among 256 steps
	output logic [8:0] ones,
	output logic done
);
	logic [1:0] dly;
	logic [8:0] n;
	assign done = n == 9'h100;
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			{dly, n, ones} <= '0;
		end else begin
			dly <= {dly[0], step};
			if (clr)
				{n, ones} <= '0;
			else if (dly[1] && !done) begin
				n <= n + 9'h1;
				ones <= ones + {8'h0, bit_in};
			end
		end
	end
endmodule

// file: test/dmsd_top_test.sv
// Self-checking bench for the sigma-delta monitor
`timescale 1ns/10ps
module dmsd_top_test import dmsd_pkg::*;;
	logic mclk, rstn, reg_wr, reg_rd, demod_tick, recovery_tick;
	logic normal_bitstream_output_pin, clr, done, pin, cdr;
	logic [3:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, v;
	logic signed [15:0] corr, lin;
	logic [8:0] ones;
	int cyc, dper, rper, err_total, checks_done, a, b;
	dmsd_top dmsd_top_inst (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .demod_tick(demod_tick), .corr_filt(corr),
		.lin_filt(lin), .recovery_tick(recovery_tick),
		.normal_bitstream_output_pin(normal_bitstream_output_pin), .bitstream_output_pin(pin),
		.cdr_disabled(cdr));
	dmsd_meter dmsd_meter_inst (.mclk(mclk), .rstn(rstn), .bit_in(pin),
		.step(recovery_tick), .clr(clr), .ones(ones), .done(done));
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		demod_tick <= cyc % dper == 0;
		recovery_tick <= cyc % rper == 0;
		normal_bitstream_output_pin <= !normal_bitstream_output_pin;
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			err_total++;
			$display("unexpected at %0t: seen %h, expected %h", $time, s, e);
		end
	endtask
	function automatic logic [31:0] rng(int x, int lo, int hi);
		return 32'(x >= lo && x <= hi);
	endfunction
	task automatic wr(input logic [3:0] ad, input logic [31:0] d);
		reg_addr <= ad;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rd(input logic [3:0] ad);
		reg_addr <= ad;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
		@(posedge mclk);
	endtask
	task automatic mode(input logic [4:0] m);
		wr(DMSD_IDX_TEST, {13'h0000, m, 14'h000C});
	endtask
	task automatic meas(output int d);
		repeat (64) @(posedge mclk);
		clr <= 1'b1;
		@(posedge mclk);
		clr <= 1'b0;
		@(posedge mclk);
		for (int i = 0; i < 5000 && !done; i++)
			@(posedge mclk);
		d = ones;
	endtask
	task automatic t_regs();
		logic [4:0] m [3] = '{DMSD_TMODE_PLAIN, DMSD_TMODE_OFFSET, 5'h03};
		logic [31:0] e [3] = '{32'h1, 32'h2, 32'h0};
		wr(4'h3, 32'hFFFF_FFFF);
		rd(4'h3);
		chk(v, 32'h0);
		wr(DMSD_IDX_CTRL, 32'h5A);
		rd(DMSD_IDX_CTRL);
		chk(v, 32'h5A);
		for (int i = 0; i < 3; i++) begin
			mode(m[i]);
			rd(DMSD_IDX_STATUS);
			chk({30'h0, v[1:0]}, e[i]);
		end
		$display("t_regs done");
	endtask
	task automatic t_plain();
		wr(DMSD_IDX_CTRL, 32'h0);
		lin <= 16'h4000;
		mode(DMSD_TMODE_PLAIN);
		meas(a);
		chk(rng(a, 120, 136), 32'h1);
		corr <= 16'h4000;
		meas(a);
		corr <= 16'hC000;
		meas(b);
		chk(rng(a + b, 248, 264), 32'h1);
		chk(rng(a > b ? a - b : b - a, 112, 144), 32'h1);
		$display("t_plain done");
	endtask
	task automatic t_offset();
		mode(5'h00);
		wr(DMSD_IDX_CTRL, 32'h1);
		lin <= 16'h03E8;
		wr(DMSD_IDX_OFFGAIN, 32'h03E8_0000);
		rd(DMSD_IDX_OFFGAIN);
		chk(v, 32'h0);
		mode(DMSD_TMODE_OFFSET);
		meas(a);
		chk(rng(a, 120, 136), 32'h1);
		wr(DMSD_IDX_OFFGAIN, 32'h0BE8_0000);
		lin <= 16'h0BE8;
		meas(a);
		lin <= 16'hFBE8;
		meas(b);
		chk(rng(a + b, 248, 264), 32'h1);
		chk(rng(a > b ? a - b : b - a, 56, 72), 32'h1);
		$display("t_offset done");
	endtask
	task automatic t_idle();
		logic p;
		mode(5'h00);
		#1;
		for (int i = 0; i < 8; i++) begin
			p = normal_bitstream_output_pin;
			@(posedge mclk);
			#1 chk({31'h0, pin}, {31'h0, p});
		end
		@(posedge mclk);
		$display("t_idle done");
	endtask
	task automatic t_cdr();
		mode(DMSD_TMODE_PLAIN);
		chk({31'h0, cdr}, 32'h1);
		rper <= 16;
		repeat (2200) @(posedge mclk);
		chk({31'h0, cdr}, 32'h0);
		rd(DMSD_IDX_STATUS);
		chk({31'h0, v[3]}, 32'h1);
		dper <= 1000000;
		repeat (64) @(posedge mclk);
		rd(DMSD_IDX_STATUS);
		rd(DMSD_IDX_STATUS);
		chk({31'h0, v[3]}, 32'h0);
		$display("t_cdr done");
	endtask
	task automatic stop_test();
		$display("checks %0d, mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		{rstn, reg_wr, reg_rd, demod_tick, recovery_tick, clr} = '0;
		{normal_bitstream_output_pin, reg_addr, reg_wdata, corr, lin} = '0;
		{cyc, err_total, checks_done} = '0;
		dper = 4;
		rper = 2;
		repeat (12) @(posedge mclk);
		rstn <= 1'b1;
		@(posedge mclk);
		t_regs();
		t_plain();
		t_offset();
		t_idle();
		t_cdr();
		stop_test();
	end
	initial begin
		#1000000;
		err_total++;
		stop_test();
	end
endmodule
